// ===== shared/cdb_params.svh
/*
 Constants for the command block decoder: lengths, field positions,
 status bit positions and message codes.
 Assumes it is included by bare name wherever these values are needed.
*/
`ifndef CDB_PARAMS_SVH
`define CDB_PARAMS_SVH
`define CDB_LEN_SHORT 4'd6
`define CDB_LEN_LONG 4'd10
`define CDB_BYTES 10
`define GROUP_SHORT 3'h0
`define GROUP_LONG 3'h1
`define UNIT_MAX 3'h3
`define COUNT_SHORT_ZERO 17'h00100
`define ST_CHECK 1
`define ST_MET 2
`define ST_BUSY 3
`define ST_CONFLICT 4
`define MSG_DONE 8'h00
`define MSG_LINKED 8'h0a
`define MSG_LINKED_FLAG 8'h0b
`define ID_MARK 7
`define ID_RECONNECT 6
`endif

// ===== shared/cdb_pkg.sv
/*
 Types shared by the command block decoder and its helpers.
 Assumes nothing of its surroundings.
*/
package cdb_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [1:0] unit_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DECODE = 2'b01,
      ST_EXEC = 2'b10,
      ST_REPORT = 2'b11
   } phase_t;
endpackage : cdb_pkg

// ===== shared/cdb_fields_if.sv
/*
 Carries the raw command block and its unpacked fields between the
 decoder top and the field unpacker.
 Assumes both ends share one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
interface cdb_fields_if;
   logic [79:0] raw;
   logic [2:0] group;
   logic [4:0] opcode;
   logic [2:0] lun;
   logic [3:0] options;
   logic rel;
   logic [31:0] addr;
   logic [16:0] count;
   logic link;
   logic flag;
   modport unpack (input raw, output group, opcode, lun, options, rel,
      addr, count, link, flag);
   modport consumer (output raw, input group, opcode, lun, options, rel,
      addr, count, link, flag);
endinterface : cdb_fields_if
`default_nettype wire

// ===== rtl/cdb_field_unpack.sv
/*
 Splits a stored six- or ten-byte command block into its fields.
 Assumes byte i of the block sits at raw[8*i +: 8]; purely combinational.
*/
`timescale 1ns/100ps
`default_nettype none
`include "cdb_params.svh"
module cdb_field_unpack (
   cdb_fields_if.unpack f
);
   // -------------------------------------------------------------------
   // Field extraction
   // -------------------------------------------------------------------
   logic long_form;
   logic [15:0] long_count;

   // Group 1 selects the ten-byte layout; anything else uses six bytes.
   assign long_form = (f.raw[7:5] == `GROUP_LONG); // R01
   assign long_count = {f.raw[63:56], f.raw[71:64]};
   assign f.group = f.raw[7:5]; // R01
   assign f.opcode = f.raw[4:0]; // R03
   assign f.lun = f.raw[15:13]; // R04
   assign f.options = long_form ? f.raw[12:9] : 4'h0; // R06
   assign f.rel = long_form & f.raw[8]; // R07
   // Short form carries 21 address bits, long form 32, MSB first.
   assign f.addr = long_form ?
      {f.raw[23:16], f.raw[31:24], f.raw[39:32], f.raw[47:40]} :
      {11'h000, f.raw[12:8], f.raw[23:16], f.raw[31:24]}; // R09
   // A zero short count means 256 blocks; a zero long count means none.
   assign f.count = long_form ? {1'b0, long_count} :
      (f.raw[39:32] == 8'h00) ? `COUNT_SHORT_ZERO :
      {9'h000, f.raw[39:32]}; // R10
   assign f.link = long_form ? f.raw[72] : f.raw[40];
   assign f.flag = long_form ? f.raw[73] : f.raw[41];
endmodule : cdb_field_unpack
`default_nettype wire

// ===== rtl/status_compose.sv
/*
 Builds the completion status byte and the ending message code.
 Assumes its inputs are stable in the cycle that reports status.
*/
`timescale 1ns/100ps
`default_nettype none
`include "cdb_params.svh"
module status_compose (
   input wire logic check,
   input wire logic met,
   input wire logic busy,
   input wire logic conflict,
   input wire logic link,
   input wire logic flag,
   output logic [7:0] status,
   output logic [7:0] message,
   output logic link_go
);
   // -------------------------------------------------------------------
   // Status and message
   // -------------------------------------------------------------------
   // Unused status bits stay zero; a conflict always carries busy.
   always_comb begin
      status = 8'h00; // R16
      status[`ST_CHECK] = check; // R17
      status[`ST_MET] = met; // R18
      status[`ST_BUSY] = busy | conflict; // R19 R20
      status[`ST_CONFLICT] = conflict; // R20
   end

   // Only a clean linked command continues the chain.
   assign link_go = link & ~check & ~busy & ~conflict; // R13 R15
   assign message = ~link_go ? `MSG_DONE :
      flag ? `MSG_LINKED_FLAG : `MSG_LINKED; // R22
endmodule : status_compose
`default_nettype wire

// ===== rtl/scsi_cdb_decode_status.sv
/*
 Command block decoder and completion status builder for a disk
 controller acting as a bus target. Collects command bytes, decodes the
 fields, resolves relative addresses inside linked chains, and returns
 status with the ending message.
 Assumes all inputs are synchronous to mclk and that the phase logic
 outside delivers bytes, identify messages and execution results.
*/
// Contract
// R01 - Byte 0 bits 7-5 are group, 4-0 opcode; group 0 six bytes, 1 ten.
// R02 - Only groups 0 and 1 are supported; initiator sends only those.
// R03 - Five-bit opcode selects one of thirty-two commands.
// R04 - Unit number from byte 1 bits 7-5; only 0 to 3 accepted.
// R05 - Block unit number used only when no identify selected a unit.
// R06 - Ten-byte byte 1 bits 4-1 are opcode-specific options.
// R07 - Ten-byte relative bit adds signed offset to unit's last address.
// R08 - Initiator uses relative addressing only in chains after an access.
// R09 - 21-bit address in six-byte form, 32-bit MSB first in ten-byte.
// R10 - Zero count is 256 blocks short, no transfer long; max 65,535.
// R11 - Initiator writes zero into control byte bits 7-2.
// R12 - Flag bit requests interrupt in chain; set only with link.
// R13 - Link bit continues to next command after success, no reselection.
// R14 - Status at every command or chain end, and after each link.
// R15 - Abnormal condition stops the command with ending status.
// R16 - Status bits 0, 5, 6 and 7 always zero.
// R17 - Status bit 1 reports check condition with sense available.
// R18 - Status bit 2 reports a satisfied search.
// R19 - Status bit 3 reports busy when a command cannot be accepted.
// R20 - Status bit 4 with bit 3 reports a reservation conflict.
// R21 - Identify: bit 7 set, bit 6 reconnect, bits 1-0 the unit.
// R22 - Linked completion sends message 0A, or 0B when flagged.
// R23 - Bad group or unit is an illegal request ending in check.
// R24 - Last accessed address kept per unit for relative commands.
`timescale 1ns/100ps
`default_nettype none
`include "cdb_params.svh"
module scsi_cdb_decode_status (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic byte_valid,
   input wire logic cdb_start,
   input wire cdb_pkg::byte_t byte_data,
   input wire logic ident_valid,
   input wire cdb_pkg::byte_t ident_byte,
   input wire logic sel_end,
   input wire logic exec_done,
   input wire logic exec_abort,
   input wire logic exec_sense,
   input wire logic exec_met,
   input wire logic exec_busy,
   input wire logic exec_conflict,
   input wire logic exec_accessed,
   input wire logic [31:0] exec_lba,
   output logic cdb_ready,
   output logic cmd_valid,
   output logic [4:0] cmd_opcode,
   output logic [2:0] cmd_group,
   output cdb_pkg::unit_t cmd_unit,
   output logic [3:0] cmd_options,
   output logic [31:0] cmd_lba,
   output logic [16:0] cmd_count,
   output logic cmd_zero,
   output logic cmd_link,
   output logic cmd_flag,
   output logic host_reconnect,
   output logic status_valid,
   output cdb_pkg::byte_t status_byte,
   output cdb_pkg::byte_t msg_byte,
   output logic chain_next,
   output logic chain_irq
);
   import cdb_pkg::*;

   // -------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------
   phase_t state;
   phase_t next_state;
   byte_t cdb_buf [`CDB_BYTES];
   logic [3:0] idx;
   logic [3:0] len_m1;
   logic take;
   logic got_all;
   logic ident_seen;
   unit_t ident_unit;
   unit_t unit;
   logic chain;
   logic [31:0] last_lba [4];
   logic [3:0] accessed;
   logic bad_group;
   logic bad_unit;
   logic bad_rel;
   logic illegal;
   logic [31:0] eff_lba;
   logic report;
   logic rep_check;
   logic rep_met;
   logic rep_busy;
   logic rep_conflict;
   byte_t next_status;
   byte_t next_msg;
   logic link_go;

   cdb_fields_if f ();

   // -------------------------------------------------------------------
   // Byte collection
   // -------------------------------------------------------------------
   // Bytes are taken only while idle; a start strobe restarts the block.
   assign take = byte_valid & (state == ST_IDLE);

   // The block length follows the group of the stored first byte.
   assign len_m1 = (cdb_buf[0][7:5] == `GROUP_LONG) ?
      (`CDB_LEN_LONG - 4'd1) : (`CDB_LEN_SHORT - 4'd1); // R01

   // The last byte of the block arrives when the index reaches length-1.
   assign got_all = take & ~cdb_start & (idx == len_m1) & (idx != 4'd0);

   // Index of the next byte position; zero means no block in progress.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         idx <= 4'd0;
      end else if (take & cdb_start) begin
         idx <= 4'd1;
      end else if (got_all) begin
         idx <= 4'd0;
      end else if (take & (idx != 4'd0)) begin
         idx <= idx + 4'd1;
      end
   end

   // One storage byte per position, written when its index comes up.
   genvar gi;
   generate
      for (gi = 0; gi < `CDB_BYTES; gi++) begin : g_buf
         always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
               cdb_buf[gi] <= 8'h00;
            end else if (take & cdb_start & (gi == 0)) begin
               cdb_buf[gi] <= byte_data;
            end else if (take & ~cdb_start & (idx != 4'd0) &
                         (idx == 4'(gi))) begin
               cdb_buf[gi] <= byte_data;
            end
         end
         assign f.raw[8*gi +: 8] = cdb_buf[gi];
      end
   endgenerate

   cdb_field_unpack u_unpack (
      .f(f.unpack)
   );

   // -------------------------------------------------------------------
   // Identify tracking
   // -------------------------------------------------------------------
   // A well-formed identify fixes the unit until the selection ends.
   // An identify in the cycle of a selection end wins over the clear.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ident_seen <= 1'b0;
         ident_unit <= 2'h0;
         host_reconnect <= 1'b0;
      end else if (ident_valid & ident_byte[`ID_MARK] &
                   (ident_byte[5:2] == 4'h0)) begin // R21
         ident_seen <= 1'b1;
         ident_unit <= ident_byte[1:0]; // R21
         host_reconnect <= ident_byte[`ID_RECONNECT]; // R21
      end else if (sel_end) begin
         ident_seen <= 1'b0;
         host_reconnect <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Decode checks
   // -------------------------------------------------------------------
   // The block's unit field counts only without an identify.
   assign unit = ident_seen ? ident_unit : f.lun[1:0]; // R05
   assign bad_unit = ~ident_seen & (f.lun > `UNIT_MAX); // R04 R23
   assign bad_group = (f.group != `GROUP_SHORT) &
      (f.group != `GROUP_LONG); // R02 R23
   // Relative addressing needs a live chain and a prior access.
   assign bad_rel = f.rel & ~(chain & accessed[unit]); // R08
   assign illegal = bad_group | bad_unit | bad_rel; // R23

   // The signed offset wraps modulo 2^32 onto the last address.
   assign eff_lba = f.rel ? (last_lba[unit] + f.addr) : f.addr; // R07

   // -------------------------------------------------------------------
   // Per-unit last access
   // -------------------------------------------------------------------
   // Each unit keeps its last accessed block for relative commands.
   genvar gu;
   generate
      for (gu = 0; gu < 4; gu++) begin : g_unit
         always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
               last_lba[gu] <= 32'h0000_0000;
               accessed[gu] <= 1'b0;
            end else if (sel_end | (report & ~link_go)) begin
               accessed[gu] <= 1'b0;
            end else if ((state == ST_EXEC) & exec_accessed &
                         (cmd_unit == 2'(gu))) begin
               last_lba[gu] <= exec_lba; // R24
               accessed[gu] <= 1'b1; // R24
            end
         end
      end
   endgenerate

   // -------------------------------------------------------------------
   // Phase sequencing
   // -------------------------------------------------------------------
   // Illegal requests report at once; good ones wait for execution.
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (got_all) begin
               next_state = ST_DECODE;
            end
         end
         ST_DECODE: begin
            next_state = illegal ? ST_REPORT : ST_EXEC; // R23
         end
         ST_EXEC: begin
            if (exec_done | exec_abort) begin
               next_state = ST_REPORT; // R15
            end
         end
         ST_REPORT: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_IDLE;
      end else if (sel_end & (state != ST_EXEC)) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // -------------------------------------------------------------------
   // Command outputs
   // -------------------------------------------------------------------
   // Fields are latched in the decode cycle and held until the next one.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cmd_opcode <= 5'h00;
         cmd_group <= 3'h0;
         cmd_unit <= 2'h0;
         cmd_options <= 4'h0;
         cmd_lba <= 32'h0000_0000;
         cmd_count <= 17'h00000;
         cmd_zero <= 1'b0;
         cmd_link <= 1'b0;
         cmd_flag <= 1'b0;
      end else if (state == ST_DECODE) begin
         cmd_opcode <= f.opcode; // R03
         cmd_group <= f.group; // R01
         cmd_unit <= unit; // R05
         cmd_options <= f.options; // R06
         cmd_lba <= eff_lba; // R07 R09
         cmd_count <= f.count; // R10
         cmd_zero <= (f.count == 17'h00000); // R10
         cmd_link <= f.link; // R13
         cmd_flag <= f.flag & f.link; // R12
      end
   end

   // A legal block is handed to execution with a one-cycle strobe.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cmd_valid <= 1'b0;
      end else begin
         cmd_valid <= (state == ST_DECODE) & ~illegal;
      end
   end

   // The decoder is ready for bytes whenever it is idle.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cdb_ready <= 1'b0;
      end else begin
         cdb_ready <= (next_state == ST_IDLE);
      end
   end

   // -------------------------------------------------------------------
   // Completion status
   // -------------------------------------------------------------------
   // Status is built on the edge that enters the report phase.
   assign report = (next_state == ST_REPORT) & (state != ST_REPORT);
   assign rep_check = (state == ST_DECODE) | exec_sense |
      exec_abort; // R15 R17 R23
   assign rep_met = (state == ST_EXEC) & exec_met; // R18
   assign rep_busy = (state == ST_EXEC) & exec_busy; // R19
   assign rep_conflict = (state == ST_EXEC) & exec_conflict; // R20

   status_compose u_status (
      .check(rep_check),
      .met(rep_met),
      .busy(rep_busy),
      .conflict(rep_conflict),
      .link((state == ST_EXEC) & cmd_link),
      .flag(cmd_flag),
      .status(next_status),
      .message(next_msg),
      .link_go(link_go)
   );

   // Every end of command, linked or not, returns a status byte.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         status_valid <= 1'b0;
         status_byte <= 8'h00;
         msg_byte <= `MSG_DONE;
      end else begin
         status_valid <= report; // R14
         if (report) begin
            status_byte <= next_status; // R14 R16
            msg_byte <= next_msg; // R22
         end
      end
   end

   // A clean linked finish keeps the chain and asks for the next block.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         chain <= 1'b0;
         chain_next <= 1'b0;
         chain_irq <= 1'b0;
      end else begin
         chain_next <= report & link_go; // R13
         chain_irq <= report & link_go & cmd_flag; // R12
         if (sel_end) begin
            chain <= 1'b0;
         end else if (report) begin
            chain <= link_go; // R13 R15
         end
      end
   end
endmodule : scsi_cdb_decode_status
`default_nettype wire

// ===== tb/scsi_cdb_decode_status_props.sv
/*
 Port checker for the command block decoder.
 Assumes it is bound to the decoder top and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module scsi_cdb_decode_status_props (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic exec_done,
   input wire logic exec_abort,
   input wire logic exec_sense,
   input wire logic exec_met,
   input wire logic exec_busy,
   input wire logic exec_conflict,
   input wire logic cdb_ready,
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_group,
   input wire logic [3:0] cmd_options,
   input wire logic [16:0] cmd_count,
   input wire logic cmd_link,
   input wire logic cmd_flag,
   input wire logic status_valid,
   input wire cdb_pkg::byte_t status_byte,
   input wire cdb_pkg::byte_t msg_byte,
   input wire logic chain_next,
   input wire logic chain_irq
);
   import cdb_pkg::*;
   logic in_exec;
   // Marks the span from a decoded command up to its status.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         in_exec <= 1'b0;
      end else if (status_valid) begin
         in_exec <= 1'b0;
      end else if (cmd_valid) begin
         in_exec <= 1'b1;
      end
   end
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!arst_n);
   // An execution result offered while a command runs.
   sequence s_end;
      (in_exec || cmd_valid) && (exec_done || exec_abort);
   endsequence
   // A result with nothing that stops a chain.
   sequence s_clean;
      !exec_abort && !exec_sense && !exec_busy && !exec_conflict;
   endsequence
   a_status_zero_bits: assert property (
      status_valid |-> status_byte[0] == 1'b0 && status_byte[7:5] == 3'h0)
      else $error("reserved status bits set");
   a_end_gives_status: assert property (s_end |=> status_valid)
      else $error("no status after execution end");
   a_abort_checks: assert property (
      s_end ##0 exec_abort |=> status_byte[1] && !chain_next)
      else $error("abort did not end with check");
   a_sense_checks: assert property (
      s_end ##0 exec_sense |=> status_byte[1])
      else $error("sense did not give check");
   a_met_bit: assert property (
      s_end |=> status_byte[2] == $past(exec_met))
      else $error("condition met bit wrong");
   a_busy_bit: assert property (
      s_end |=> status_byte[3] == $past(exec_busy || exec_conflict))
      else $error("busy bit wrong");
   a_conflict_bit: assert property (
      s_end |=> status_byte[4] == $past(exec_conflict))
      else $error("conflict bit wrong");
   a_chain_go: assert property (
      s_end ##0 s_clean ##0 cmd_link |=> chain_next
      && msg_byte == (cmd_flag ? 8'h0b : 8'h0a))
      else $error("linked completion wrong");
   a_chain_stop: assert property (
      s_end ##0 !cmd_link |=> !chain_next && msg_byte == 8'h00)
      else $error("unlinked completion wrong");
   a_irq_with_next: assert property (
      chain_irq |-> chain_next && msg_byte == 8'h0b)
      else $error("flag message without chain");
   a_flag_link: assert property (
      cmd_valid && cmd_flag |-> cmd_link)
      else $error("flag shown without link");
   a_group_legal: assert property (
      cmd_valid |-> cmd_group <= 3'h1)
      else $error("unsupported group decoded");
   a_short_fields: assert property (
      cmd_valid && cmd_group == 3'h0 |-> cmd_options == 4'h0
      && cmd_count != 17'h0 && cmd_count <= 17'h00100)
      else $error("short block fields wrong");
   a_ready_back: assert property (status_valid |=> cdb_ready)
      else $error("not ready after status");
endmodule : scsi_cdb_decode_status_props
bind scsi_cdb_decode_status scsi_cdb_decode_status_props i_props (.*);
`default_nettype wire

// ===== tb/cdb_host_model.sv
/*
 Behavioural initiator that hands command blocks and identify bytes over.
 Assumes the decoder's byte interface and one clock.
*/
`timescale 1ns/100ps
`default_nettype none
module cdb_host_model (
   input wire logic mclk,
   input wire logic cdb_ready,
   output logic byte_valid,
   output logic cdb_start,
   output cdb_pkg::byte_t byte_data,
   output logic ident_valid,
   output cdb_pkg::byte_t ident_byte
);
   import cdb_pkg::*;
   initial begin
      byte_valid = 1'b0;
      cdb_start = 1'b0;
      byte_data = 8'h00;
      ident_valid = 1'b0;
      ident_byte = 8'h00;
   end
   task automatic tick;
      @(posedge mclk);
      #10;
   endtask : tick
   // Control byte with reserved bits clear and flag only beside link.
   function automatic byte_t ctl(input logic flag, input logic link);
      return {6'h00, flag & link, link};
   endfunction : ctl
   // Identify byte; the line shows the inverse once released.
   task automatic send_ident(input unit_t unit, input logic recon);
      ident_byte = {1'b1, recon, 4'h0, unit};
      ident_valid = 1'b1;
      tick();
      ident_valid = 1'b0;
      ident_byte = ~ident_byte;
   endtask : send_ident
   // Waits for ready, then sends six or ten bytes by group.
   task automatic send_cmd(input logic [79:0] blk, output logic ok);
      int n;
      n = (blk[7:5] == 3'h1) ? 10 : 6;
      ok = 1'b0;
      for (int t = 0; t < 40 && !ok; t++) begin
         tick();
         ok = cdb_ready;
      end
      // The control byte is rebuilt so reserved bits always go out clear.
      for (int i = 0; i < n && ok; i++) begin
         byte_valid = 1'b1;
         cdb_start = (i == 0);
         byte_data = (i == n - 1) ? ctl(blk[8*i+1], blk[8*i]) :
            blk[8*i +: 8];
         tick();
      end
      byte_valid = 1'b0;
      cdb_start = 1'b0;
      byte_data = ~byte_data;
   endtask : send_cmd
endmodule : cdb_host_model
`default_nettype wire

// ===== tb/tb_scsi_cdb_decode_status.sv
/*
 Self-checking bench for the command block decoder.
 Assumes the host model and the bound checker are compiled with it.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_scsi_cdb_decode_status;
   import cdb_pkg::*;
   typedef struct {
      logic [79:0] blk;
      logic [4:0] op;
      logic [3:0] opt;
      unit_t unit;
      logic [31:0] lba;
      logic [16:0] cnt;
      byte_t msg;
   } row_t;
   logic mclk, arst_n, byte_valid, cdb_start, ident_valid, sel_end;
   logic exec_done, exec_abort, exec_sense, exec_met, exec_busy;
   logic exec_conflict, exec_accessed, cdb_ready, cmd_valid, cmd_zero;
   logic cmd_link, cmd_flag, host_reconnect, status_valid;
   logic chain_next, chain_irq, dec;
   byte_t byte_data, ident_byte, status_byte, msg_byte;
   logic [31:0] exec_lba, cmd_lba;
   logic [4:0] cmd_opcode, res;
   logic [2:0] cmd_group;
   logic [3:0] cmd_options;
   logic [16:0] cmd_count;
   unit_t cmd_unit;
   int failures, cmp_count;
   row_t rows [3];
   scsi_cdb_decode_status i_dut (.*);
   cdb_host_model i_host (.*);
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task automatic tick;
      @(posedge mclk);
      #10;
   endtask : tick
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen,
            exp);
      end
   endtask : chk
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : give_verdict
   // Sends a block, runs it with result flags {conflict,busy,met,sense,
   // abort} and returns at the status cycle.
   task automatic do_cmd(input logic [79:0] blk, input logic [4:0] r,
         input logic [31:0] lba);
      logic ok;
      i_host.send_cmd(blk, ok);
      chk(ok, 1'b1);
      for (int t = 0; t < 8 && !cmd_valid && !status_valid; t++) begin
         tick();
      end
      dec = cmd_valid;
      if (cmd_valid) begin
         exec_accessed = 1'b1;
         exec_lba = lba;
         tick();
         exec_accessed = 1'b0;
         {exec_conflict, exec_busy, exec_met, exec_sense, exec_abort} = r;
         exec_done = !r[0];
         tick();
         {exec_conflict, exec_busy, exec_met, exec_sense, exec_abort} = 0;
         exec_done = 1'b0;
      end
      chk(status_valid, 1'b1);
   endtask : do_cmd
   initial begin
      {sel_end, exec_done, exec_abort, exec_sense, exec_met} = 0;
      {exec_busy, exec_conflict, exec_accessed, exec_lba} = 0;
      failures = 0;
      cmp_count = 0;
      arst_n = 1'b0;
      rows[0] = '{80'h00000000000056345a08, 5'h08, 4'h0, 2'h2,
         32'h001a3456, 17'h00100, 8'h00};
      rows[1] = '{80'h03ffff0078563412743f, 5'h1f, 4'ha, 2'h3,
         32'h12345678, 17'h0ffff, 8'h0b};
      rows[2] = '{80'h01000000ffffffff0020, 5'h00, 4'h0, 2'h0,
         32'hffffffff, 17'h00000, 8'h0a};
      repeat (8) @(posedge mclk);
      #10;
      arst_n = 1'b1;
      tick();
      chk(cdb_ready, 1'b1);
      chk({status_valid, cmd_valid, msg_byte}, 10'h0);
      foreach (rows[i]) begin
         do_cmd(rows[i].blk, 5'h0, 32'h0);
         chk(dec, 1'b1);
         chk(cmd_opcode, rows[i].op);
         chk(cmd_group, rows[i].blk[7:5]);
         chk(cmd_unit, rows[i].unit);
         chk(cmd_options, rows[i].opt);
         chk(cmd_lba, rows[i].lba);
         chk(cmd_count, rows[i].cnt);
         chk(status_byte, 8'h00);
         chk(msg_byte, rows[i].msg);
         chk(chain_next, rows[i].msg != 8'h00);
         chk(chain_irq, rows[i].msg == 8'h0b);
      end
      chk(cmd_zero, 1'b1);
      sel_end = 1'b1;
      tick();
      sel_end = 1'b0;
      i_host.send_ident(2'h1, 1'b1);
      chk(host_reconnect, 1'b1);
      do_cmd(80'h0000000001010000a008, 5'h0, 32'h00000100);
      chk(cmd_unit, 2'h1);
      chk(chain_next, 1'b1);
      do_cmd(80'h00010000f0ffffff0128, 5'h0, 32'h0);
      chk(cmd_lba, 32'h000000f0);
      chk(chain_next, 1'b0);
      do_cmd(80'h00010000f0ffffff0128, 5'h0, 32'h0);
      chk({dec, status_byte, msg_byte}, 17'h00200);
      sel_end = 1'b1;
      tick();
      sel_end = 1'b0;
      do_cmd(80'h00000000000100000048, 5'h0, 32'h0);
      chk({dec, status_byte, msg_byte}, 17'h00200);
      do_cmd(80'h00000000000100008008, 5'h0, 32'h0);
      chk({dec, status_byte, msg_byte}, 17'h00200);
      foreach (rows[i]) begin
         res = (i == 0) ? 5'h04 : (i == 1) ? 5'h08 : 5'h10;
         do_cmd(80'h00000000010100000000, res, 32'h0);
         chk(status_byte,
            {3'h0, res[4], res[4] | res[3], res[2], 2'h0});
         chk(chain_next, res == 5'h04);
      end
      do_cmd(80'h00000000010100000000, 5'h03, 32'h0);
      chk(status_byte, 8'h02);
      chk(chain_next, 1'b0);
      arst_n = 1'b0;
      tick();
      chk({status_valid, cmd_valid, msg_byte}, 10'h0);
      chk(cmd_lba, 32'h0000_0000);
      arst_n = 1'b1;
      tick();
      tick();
      chk(cdb_ready, 1'b1);
      give_verdict();
   end
endmodule : tb_scsi_cdb_decode_status
`default_nettype wire
